// file: design/cmm_ctrl.sv
// Purpose: cpu control registers (fetch counter, status word, stack pointer) and map decode
// Assumes: sequencer and memories share SYS_CLK; MEM_RDATA valid the cycle after MEM_RE
// Notes: sequencer ops are taken only while SEQ_BUSY is low
//
// Functional notes
// (RL1) flash program memory 0000 to 7fff
// (RL2) 0000 to 003f holds the vector table
// (RL3) vector low byte even, high byte odd
// (RL4) reset loads fetch counter from 0000/0001
// (RL5) interrupt slots 0004..003c, 0026 unused
// (RL6) table call, option byte, fixed call areas
// (RL7) 1024 byte ram at fb00 to feff
// (RL8) fee0 to feff hold four register banks
// (RL9) no instruction fetch from ram
// (RL10) peripheral registers decoded at ff00 to ffff
// (RL11) counter advances by length or branch load
// (RL12) status word pushed and popped on stack
// (RL13) reset sets status word to 02
// (RL14) interrupt enable clear blocks maskable interrupts
// (RL15) disable, accept clear enable; enable op sets
// (RL16) zero flag follows zero result
// (RL17) bank select field set by bank switch
// (RL18) half carry from bit three
// (RL19) low priority blocked while service flag zero
// (RL20) carry takes overflow, shift out, bit ops
// (RL21) stack pointer predecrement write, postincrement read
// (RL22) stack lives only in internal ram
// (RL23) eight byte registers pair into four pairs
// (RL24) wide peripheral access needs even address
// (RL25) status word bit layout fixed
// (RL26) unassigned peripheral addresses ignore writes
`timescale 1ns/1ps
`default_nettype none
module cmm_ctrl #(
	parameter int LEN_W = 3
) (
	input wire logic SYS_CLK,
	input wire logic RST,
	input wire logic PSEL,
	input wire logic PENABLE,
	input wire logic PWRITE,
	input wire logic [11:0] PADDR,
	input wire logic [31:0] PWDATA,
	output logic [31:0] PRDATA,
	output logic PREADY,
	output logic PSLVERR,
	input wire logic [3:0] SEQ_OP,
	input wire logic [15:0] SEQ_ARG,
	output logic SEQ_BUSY,
	input wire logic ALU_WE,
	input wire logic [7:0] ALU_RESULT,
	input wire logic ALU_HALF,
	input wire logic ALU_CARRY,
	input wire logic IRQ_PENDING,
	input wire logic IRQ_LOW_PRIO,
	output logic IRQ_ALLOW,
	output logic [15:0] FETCH_ADDR,
	output logic FETCH_FAULT,
	output logic [7:0] PSW_VALUE,
	output logic [15:0] SP_VALUE,
	output logic [15:0] BANK_BASE,
	input wire logic [15:0] DATA_ADDR,
	input wire logic DATA_WIDE,
	output logic [1:0] DATA_REGION,
	output logic DATA_IN_BANK,
	output logic DATA_SFR_BAD,
	output logic [15:0] MEM_ADDR,
	output logic [7:0] MEM_WDATA,
	output logic MEM_WE,
	output logic MEM_RE,
	input wire logic [7:0] MEM_RDATA
);
	// elaboration check on instruction length field
	if (LEN_W < 1 || LEN_W > 4) begin : g_len_chk
		$error("LEN_W must be 1 to 4");
	end

	typedef enum logic [2:0] {ST_IDLE, ST_PUSH, ST_READ, ST_WAIT, ST_CAPTURE} cmm_state_t;

	cmm_state_t state_q, state_d;
	logic [15:0] pc_q, pc_d, sp_q, sp_d, rd_addr_q, rd_addr_d, vec_q, vec_d;
	logic [7:0] psw_q, psw_d;
	logic [23:0] push_q, push_d, rd_buf_q, rd_buf_d;
	logic [1:0] push_cnt_q, push_cnt_d, rd_cnt_q, rd_cnt_d, rd_idx_q, rd_idx_d;
	logic rd_stack_q, rd_stack_d, vec_go_q, vec_go_d;
	cmm_pkg::cmm_load_t rd_kind_q, rd_kind_d;
	logic [15:0] mem_addr_d;
	logic [7:0] mem_wdata_d;
	logic mem_we_d, mem_re_d, stack_access;
	logic apb_setup, apb_wr, apb_hit;
	logic [31:0] rdata_d;
	logic stack_fault_q;
	cmm_pkg::cmm_region_t fetch_rg, data_rg, stack_rg;
	logic data_bank;

	////////////////////////////////////////////////////////////////////////
	// map decode for fetch, data and stack addresses
	cmm_region_dec u_fetch_dec (
		.addr(pc_q),
		.region(fetch_rg),
		.in_vector(),
		.vec_slot(),
		.in_table_call_op(),
		.in_option(),
		.in_fixed_area_call_op(),
		.in_bank()
	);
	cmm_region_dec u_data_dec (
		.addr(DATA_ADDR),
		.region(data_rg),
		.in_vector(),
		.vec_slot(),
		.in_table_call_op(),
		.in_option(),
		.in_fixed_area_call_op(),
		.in_bank(data_bank)
	);
	cmm_region_dec u_stack_dec (
		.addr(mem_addr_d),
		.region(stack_rg),
		.in_vector(),
		.vec_slot(),
		.in_table_call_op(),
		.in_option(),
		.in_fixed_area_call_op(),
		.in_bank()
	);

	////////////////////////////////////////////////////////////////////////
	// apb decode; writes land at the edge that samples pready
	assign apb_setup = PSEL && !PENABLE;
	assign apb_hit = PADDR == cmm_pkg::REG_PSW || PADDR == cmm_pkg::REG_SP
		|| PADDR == cmm_pkg::REG_PC || PADDR == cmm_pkg::REG_STAT;
	assign apb_wr = PSEL && PENABLE && PREADY && PWRITE && apb_hit;

	// read mux, captured during setup
	always_comb begin
		rdata_d = 32'h0000_0000;
		case (PADDR)
			cmm_pkg::REG_PSW: rdata_d = {24'h00_0000, psw_q};
			cmm_pkg::REG_SP: rdata_d = {16'h0000, sp_q};
			cmm_pkg::REG_PC: rdata_d = {16'h0000, pc_q};
			cmm_pkg::REG_STAT: begin
				rdata_d[cmm_pkg::STAT_STACK_FAULT] = stack_fault_q;
				rdata_d[cmm_pkg::STAT_FETCH_FAULT] = FETCH_FAULT;
				rdata_d[cmm_pkg::STAT_BUSY] = SEQ_BUSY;
			end
			default: rdata_d = 32'h0000_0000;
		endcase
	end

	// apb answer: ready in the first access cycle
	always_ff @(posedge SYS_CLK) begin
		if (RST) begin
			PREADY <= 1'b0;
			PSLVERR <= 1'b0;
			PRDATA <= 32'h0000_0000;
		end else begin
			PREADY <= apb_setup;
			PSLVERR <= apb_setup && !apb_hit;
			if (apb_setup) begin
				PRDATA <= PWRITE ? 32'h0000_0000 : rdata_d;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// sequencer: ops, stack pushes and byte reads
	always_comb begin
		state_d = state_q;
		pc_d = pc_q;
		psw_d = psw_q;
		sp_d = sp_q;
		push_d = push_q;
		push_cnt_d = push_cnt_q;
		rd_addr_d = rd_addr_q;
		rd_cnt_d = rd_cnt_q;
		rd_idx_d = rd_idx_q;
		rd_kind_d = rd_kind_q;
		rd_stack_d = rd_stack_q;
		rd_buf_d = rd_buf_q;
		vec_d = vec_q;
		vec_go_d = vec_go_q;
		mem_addr_d = MEM_ADDR;
		mem_wdata_d = MEM_WDATA;
		mem_we_d = 1'b0;
		mem_re_d = 1'b0;
		stack_access = 1'b0;
		// alu flag update
		if (ALU_WE) begin
			psw_d[cmm_pkg::PSW_Z] = ALU_RESULT == 8'h00; // RL16
			psw_d[cmm_pkg::PSW_AC] = ALU_HALF; // RL18
			psw_d[cmm_pkg::PSW_CY] = ALU_CARRY; // RL20
		end
		// software writes; sequencer below takes precedence
		if (apb_wr && PADDR == cmm_pkg::REG_PSW) begin
			psw_d = PWDATA[7:0]; // RL25
		end
		if (apb_wr && PADDR == cmm_pkg::REG_SP) begin
			sp_d = PWDATA[15:0];
		end
		case (state_q)
			ST_IDLE: begin
				rd_idx_d = 2'd0;
				case (SEQ_OP)
					cmm_pkg::OP_ADVANCE: pc_d = pc_q + {{(16 - LEN_W){1'b0}}, SEQ_ARG[LEN_W-1:0]}; // RL11
					cmm_pkg::OP_BRANCH: pc_d = SEQ_ARG; // RL11
					cmm_pkg::OP_DI: psw_d[cmm_pkg::PSW_IE] = 1'b0; // RL15
					cmm_pkg::OP_EI: psw_d[cmm_pkg::PSW_IE] = 1'b1; // RL15
					cmm_pkg::OP_SEL_BANK: begin
						psw_d[cmm_pkg::PSW_BANK_SELECT_HIGH] = SEQ_ARG[1]; // RL17
						psw_d[cmm_pkg::PSW_BANK_SELECT_LOW] = SEQ_ARG[0];
					end
					cmm_pkg::OP_PUSH_PSW: begin
						push_d = {16'h0000, psw_q}; // RL12
						push_cnt_d = 2'd1;
						vec_go_d = 1'b0;
						state_d = ST_PUSH;
					end
					cmm_pkg::OP_IRQ_ACCEPT: begin
						push_d = {pc_q[7:0], pc_q[15:8], psw_q}; // RL12
						push_cnt_d = 2'd3;
						psw_d[cmm_pkg::PSW_IE] = 1'b0; // RL15
						vec_d = SEQ_ARG;
						vec_go_d = 1'b1;
						state_d = ST_PUSH;
					end
					cmm_pkg::OP_POP_PSW: begin
						rd_stack_d = 1'b1;
						rd_cnt_d = 2'd1;
						rd_kind_d = cmm_pkg::LD_PSW; // RL12
						state_d = ST_READ;
					end
					cmm_pkg::OP_INT_RETURN, cmm_pkg::OP_BREAK_RETURN: begin
						rd_stack_d = 1'b1;
						rd_cnt_d = 2'd3;
						rd_kind_d = cmm_pkg::LD_PC_PSW; // RL12
						state_d = ST_READ;
					end
					default: state_d = ST_IDLE;
				endcase
			end
			ST_PUSH: begin
				sp_d = sp_q - 16'h0001; // RL21
				mem_addr_d = sp_q - 16'h0001;
				mem_wdata_d = push_q[7:0];
				mem_we_d = 1'b1;
				stack_access = 1'b1;
				push_d = {8'h00, push_q[23:8]};
				push_cnt_d = push_cnt_q - 2'd1;
				if (push_cnt_q == 2'd1) begin
					state_d = vec_go_q ? ST_READ : ST_IDLE;
					rd_addr_d = vec_q;
					rd_stack_d = 1'b0;
					rd_cnt_d = 2'd2;
					rd_idx_d = 2'd0;
					rd_kind_d = cmm_pkg::LD_PC;
				end
			end
			ST_READ: begin
				mem_addr_d = rd_stack_q ? sp_q : rd_addr_q + {14'h0000, rd_idx_q}; // RL3
				mem_re_d = 1'b1;
				stack_access = rd_stack_q;
				state_d = ST_WAIT;
			end
			ST_WAIT: state_d = ST_CAPTURE;
			ST_CAPTURE: begin
				rd_buf_d[rd_idx_q*8 +: 8] = MEM_RDATA;
				if (rd_stack_q) begin
					sp_d = sp_q + 16'h0001; // RL21
				end
				if (rd_idx_q == rd_cnt_q - 2'd1) begin
					state_d = ST_IDLE;
					case (rd_kind_q)
						cmm_pkg::LD_PC: pc_d = rd_buf_d[15:0]; // RL3 RL4
						cmm_pkg::LD_PSW: psw_d = rd_buf_d[7:0]; // RL12
						default: begin
							pc_d = rd_buf_d[15:0];
							psw_d = rd_buf_d[23:16]; // RL12
						end
					endcase
				end else begin
					rd_idx_d = rd_idx_q + 2'd1;
					state_d = ST_READ;
				end
			end
			default: state_d = ST_IDLE;
		endcase
	end

	// state and read bookkeeping; reset starts the vector read at 0000
	always_ff @(posedge SYS_CLK) begin
		if (RST) begin
			state_q <= ST_READ; // RL4
			rd_addr_q <= cmm_pkg::RESET_VEC; // RL4
			rd_cnt_q <= 2'd2;
			rd_idx_q <= 2'd0;
			rd_kind_q <= cmm_pkg::LD_PC;
			rd_stack_q <= 1'b0;
			rd_buf_q <= 24'h00_0000;
			push_q <= 24'h00_0000;
			push_cnt_q <= 2'd0;
			vec_q <= 16'h0000;
			vec_go_q <= 1'b0;
		end else begin
			state_q <= state_d;
			rd_addr_q <= rd_addr_d;
			rd_cnt_q <= rd_cnt_d;
			rd_idx_q <= rd_idx_d;
			rd_kind_q <= rd_kind_d;
			rd_stack_q <= rd_stack_d;
			rd_buf_q <= rd_buf_d;
			push_q <= push_d;
			push_cnt_q <= push_cnt_d;
			vec_q <= vec_d;
			vec_go_q <= vec_go_d;
		end
	end

	// fetch address counter
	always_ff @(posedge SYS_CLK) begin
		if (RST) begin
			pc_q <= cmm_pkg::RESET_VEC;
		end else begin
			pc_q <= pc_d;
		end
	end

	// status flags word
	always_ff @(posedge SYS_CLK) begin
		if (RST) begin
			psw_q <= cmm_pkg::PSW_RST; // RL13
		end else begin
			psw_q <= psw_d;
		end
	end

	// stack pointer, content meaningless until software loads it
	always_ff @(posedge SYS_CLK) begin
		if (RST) begin
			sp_q <= cmm_pkg::SP_RST; // RL22
		end else begin
			sp_q <= sp_d;
		end
	end

	// memory bus strobes
	always_ff @(posedge SYS_CLK) begin
		if (RST) begin
			MEM_ADDR <= 16'h0000;
			MEM_WDATA <= 8'h00;
			MEM_WE <= 1'b0;
			MEM_RE <= 1'b0;
		end else begin
			MEM_ADDR <= mem_addr_d;
			MEM_WDATA <= mem_wdata_d;
			MEM_WE <= mem_we_d;
			MEM_RE <= mem_re_d;
		end
	end

	// sticky stack fault; a new fault wins over the clear
	always_ff @(posedge SYS_CLK) begin
		if (RST) begin
			stack_fault_q <= 1'b0;
		end else if (stack_access && stack_rg != cmm_pkg::RG_RAM) begin
			stack_fault_q <= 1'b1; // RL22
		end else if (apb_wr && PADDR == cmm_pkg::REG_STAT && PWDATA[cmm_pkg::STAT_STACK_FAULT]) begin
			stack_fault_q <= 1'b0;
		end
	end

	// status outputs, interrupt gate and decode results
	always_ff @(posedge SYS_CLK) begin
		if (RST) begin
			SEQ_BUSY <= 1'b1;
			IRQ_ALLOW <= 1'b0;
			FETCH_ADDR <= cmm_pkg::RESET_VEC;
			FETCH_FAULT <= 1'b0;
			PSW_VALUE <= cmm_pkg::PSW_RST;
			SP_VALUE <= cmm_pkg::SP_RST;
			BANK_BASE <= cmm_pkg::BANK_LO;
			DATA_REGION <= 2'b00;
			DATA_IN_BANK <= 1'b0;
			DATA_SFR_BAD <= 1'b0;
		end else begin
			SEQ_BUSY <= state_d != ST_IDLE;
			IRQ_ALLOW <= IRQ_PENDING && psw_q[cmm_pkg::PSW_IE] // RL14
				&& (psw_q[cmm_pkg::PSW_ISP] || !IRQ_LOW_PRIO); // RL19
			FETCH_ADDR <= pc_q; // RL1
			FETCH_FAULT <= fetch_rg != cmm_pkg::RG_FLASH; // RL9
			PSW_VALUE <= psw_q;
			SP_VALUE <= sp_q;
			BANK_BASE <= cmm_pkg::BANK_LO
				+ {11'h000, psw_q[cmm_pkg::PSW_BANK_SELECT_HIGH], psw_q[cmm_pkg::PSW_BANK_SELECT_LOW], 3'b000}; // RL17 RL23
			DATA_REGION <= data_rg; // RL10 RL26
			DATA_IN_BANK <= data_bank; // RL8
			DATA_SFR_BAD <= data_rg == cmm_pkg::RG_SFR && DATA_WIDE && DATA_ADDR[0]; // RL24
		end
	end

	////////////////////////////////////////////////////////////////////////
	// checks
	sequence s_push_byte;
		state_q == ST_PUSH;
	endsequence
	sequence s_pop_byte;
		state_q == ST_CAPTURE && rd_stack_q;
	endsequence

	AST_RESET_PSW: assert property (@(posedge SYS_CLK) disable iff (RST) // RL13
		$fell(RST) |-> psw_q == cmm_pkg::PSW_RST)
		else $error("status word not 02 after reset");
	AST_RESET_VECTOR: assert property (@(posedge SYS_CLK) disable iff (RST) // RL4
		$fell(RST) |=> MEM_RE && MEM_ADDR == cmm_pkg::RESET_VEC ##3 MEM_RE
		&& MEM_ADDR == 16'h0001)
		else $error("reset vector not read from 0000 and 0001");
	AST_VECTOR_ORDER: assert property (@(posedge SYS_CLK) disable iff (RST) // RL3
		(state_q == ST_CAPTURE && rd_kind_q == cmm_pkg::LD_PC && rd_idx_q == 2'd1)
		|=> pc_q == {$past(MEM_RDATA), $past(rd_buf_q[7:0])})
		else $error("vector bytes assembled in wrong order");
	AST_ADVANCE: assert property (@(posedge SYS_CLK) disable iff (RST) // RL11
		(state_q == ST_IDLE && SEQ_OP == cmm_pkg::OP_ADVANCE)
		|=> pc_q == $past(pc_q) + {{(16 - LEN_W){1'b0}}, $past(SEQ_ARG[LEN_W-1:0])})
		else $error("fetch counter did not advance by length");
	AST_SP_PREDEC: assert property (@(posedge SYS_CLK) disable iff (RST) // RL21
		s_push_byte |=> MEM_WE && MEM_ADDR == sp_q && sp_q == $past(sp_q) - 16'h0001)
		else $error("stack write not at predecremented pointer");
	AST_SP_POSTINC: assert property (@(posedge SYS_CLK) disable iff (RST) // RL21
		s_pop_byte |=> sp_q == $past(sp_q) + 16'h0001)
		else $error("stack pointer not incremented after read");
	AST_ACCEPT_CLR_IE: assert property (@(posedge SYS_CLK) disable iff (RST) // RL15
		(state_q == ST_IDLE && SEQ_OP == cmm_pkg::OP_IRQ_ACCEPT)
		|=> !psw_q[cmm_pkg::PSW_IE] ##1 MEM_WE && MEM_WDATA == $past(psw_q, 2))
		else $error("accept did not clear enable and push status");
	AST_IRQ_GATE: assert property (@(posedge SYS_CLK) disable iff (RST) // RL14
		IRQ_ALLOW |-> $past(psw_q[cmm_pkg::PSW_IE])
		&& ($past(psw_q[cmm_pkg::PSW_ISP]) || !$past(IRQ_LOW_PRIO)))
		else $error("interrupt allowed while gated off");
	AST_ZERO_FLAG: assert property (@(posedge SYS_CLK) disable iff (RST) // RL16
		(ALU_WE && state_q == ST_IDLE && SEQ_OP == cmm_pkg::OP_NONE && !apb_wr)
		|=> psw_q[cmm_pkg::PSW_Z] == ($past(ALU_RESULT) == 8'h00))
		else $error("zero flag does not follow result");
	AST_RAM_FETCH: assert property (@(posedge SYS_CLK) disable iff (RST) // RL9
		(pc_q >= cmm_pkg::RAM_LO && pc_q <= cmm_pkg::RAM_HI) |=> FETCH_FAULT)
		else $error("fetch from ram not flagged");
endmodule
`default_nettype wire

// file: design/cmm_pkg.sv
// Purpose: shared constants for the cpu memory map and control registers
// Assumes: 16-bit byte address space, 8-bit data memory
// Notes: apb offsets are byte addresses of 32-bit words
package cmm_pkg;
	// memory map
	localparam logic [15:0] FLASH_LO = 16'h0000;
	localparam logic [15:0] FLASH_HI = 16'h7fff;
	localparam logic [15:0] VEC_HI = 16'h003f;
	localparam logic [15:0] VEC_IRQ_LO = 16'h0004;
	localparam logic [15:0] VEC_IRQ_HI = 16'h003c;
	localparam logic [15:0] VEC_UNUSED = 16'h0026;
	localparam logic [15:0] TABLE_CALL_OP_LO = 16'h0040;
	localparam logic [15:0] TABLE_CALL_OP_HI = 16'h007f;
	localparam logic [15:0] OPTION_BYTE = 16'h0080;
	localparam logic [15:0] FIXED_AREA_CALL_OP_LO = 16'h0800;
	localparam logic [15:0] FIXED_AREA_CALL_OP_HI = 16'h0fff;
	localparam logic [15:0] RAM_LO = 16'hfb00;
	localparam logic [15:0] RAM_HI = 16'hfeff;
	localparam logic [15:0] BANK_LO = 16'hfee0;
	localparam logic [15:0] SFR_LO = 16'hff00;
	localparam logic [15:0] RESET_VEC = 16'h0000;
	// status flags word layout
	localparam int PSW_IE = 7;
	localparam int PSW_Z = 6;
	localparam int PSW_BANK_SELECT_HIGH = 5;
	localparam int PSW_AC = 4;
	localparam int PSW_BANK_SELECT_LOW = 3;
	localparam int PSW_ISP = 1;
	localparam int PSW_CY = 0;
	localparam logic [7:0] PSW_RST = 8'h02;
	localparam logic [15:0] SP_RST = 16'h0000;
	// apb register offsets
	localparam logic [11:0] REG_PSW = 12'h000;
	localparam logic [11:0] REG_SP = 12'h004;
	localparam logic [11:0] REG_PC = 12'h008;
	localparam logic [11:0] REG_STAT = 12'h00c;
	localparam int STAT_STACK_FAULT = 0;
	localparam int STAT_FETCH_FAULT = 1;
	localparam int STAT_BUSY = 2;
	// sequencer operations
	localparam logic [3:0] OP_NONE = 4'h0;
	localparam logic [3:0] OP_ADVANCE = 4'h1;
	localparam logic [3:0] OP_BRANCH = 4'h2;
	localparam logic [3:0] OP_DI = 4'h3;
	localparam logic [3:0] OP_EI = 4'h4;
	localparam logic [3:0] OP_IRQ_ACCEPT = 4'h5;
	localparam logic [3:0] OP_PUSH_PSW = 4'h6;
	localparam logic [3:0] OP_POP_PSW = 4'h7;
	localparam logic [3:0] OP_INT_RETURN = 4'h8;
	localparam logic [3:0] OP_BREAK_RETURN = 4'h9;
	localparam logic [3:0] OP_SEL_BANK = 4'ha;
	// address regions
	typedef enum logic [1:0] {RG_FLASH, RG_RAM, RG_SFR, RG_VOID} cmm_region_t;
	// what a finished read loads
	typedef enum logic [1:0] {LD_PC, LD_PSW, LD_PC_PSW} cmm_load_t;
endpackage

// file: design/cmm_region_dec.sv
// Purpose: combinational decode of one 16-bit address against the memory map
// Assumes: address is stable for the cycle it is decoded in
// Notes: instantiated for the fetch, data and stack addresses
`timescale 1ns/1ps
`default_nettype none
module cmm_region_dec (
	input wire logic [15:0] addr,
	output cmm_pkg::cmm_region_t region,
	output logic in_vector,
	output logic vec_slot,
	output logic in_table_call_op,
	output logic in_option,
	output logic in_fixed_area_call_op,
	output logic in_bank
);
	// region select and sub-areas of flash and ram
	always_comb begin
		if (addr <= cmm_pkg::FLASH_HI) begin // RL1
			region = cmm_pkg::RG_FLASH;
		end else if (addr >= cmm_pkg::RAM_LO && addr <= cmm_pkg::RAM_HI) begin // RL7
			region = cmm_pkg::RG_RAM;
		end else if (addr >= cmm_pkg::SFR_LO) begin // RL10
			region = cmm_pkg::RG_SFR;
		end else begin
			region = cmm_pkg::RG_VOID;
		end
	end
	assign in_vector = addr <= cmm_pkg::VEC_HI; // RL2
	// even slots 0004..003c, one slot has no source
	assign vec_slot = addr >= cmm_pkg::VEC_IRQ_LO && addr <= cmm_pkg::VEC_IRQ_HI
		&& !addr[0] && addr != cmm_pkg::VEC_UNUSED; // RL5
	assign in_table_call_op = addr >= cmm_pkg::TABLE_CALL_OP_LO && addr <= cmm_pkg::TABLE_CALL_OP_HI; // RL6
	assign in_option = addr == cmm_pkg::OPTION_BYTE; // RL6
	assign in_fixed_area_call_op = addr >= cmm_pkg::FIXED_AREA_CALL_OP_LO && addr <= cmm_pkg::FIXED_AREA_CALL_OP_HI; // RL6
	assign in_bank = addr >= cmm_pkg::BANK_LO && addr <= cmm_pkg::RAM_HI; // RL8
endmodule
`default_nettype wire

// file: testbench/cmm_mem_model.sv
// Purpose: behavioural on-chip memory seen by the control block
// Assumes: read data wanted the cycle after the read strobe
// Notes: data line toggles whenever no read answer is due
`timescale 1ns/1ps
`default_nettype none
module cmm_mem_model (
	input wire logic clk,
	input wire logic [15:0] addr,
	input wire logic [7:0] wdata,
	input wire logic we,
	input wire logic re,
	output logic [7:0] rdata
);
	logic [7:0] mem [0:65535];
	initial rdata = 8'h5a;
	////////////////////////////////////////////////////////////
	// flat byte store, flash low and ram high, vector low byte even
	always @(posedge clk) begin
		if (we) begin
			mem[addr] <= wdata;
		end
		if (re) begin
			rdata <= mem[addr];
		end else begin
			rdata <= ~rdata; // stale data never holds
		end
	end
endmodule
`default_nettype wire

// file: testbench/cmm_ctrl_test.sv
// Purpose: self-checking bench for the cpu control registers
// Assumes: apb master and sequencer driven on rising edges
// Notes: memory model preloaded with reset and irq vectors
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) check(32'(g), 32'(e))
module cmm_ctrl_test;
	logic SYS_CLK = 1'b0, RST = 1'b1, PSEL = 1'b0, PENABLE = 1'b0, PWRITE = 1'b0;
	logic [11:0] PADDR = 12'h000;
	logic [31:0] PWDATA = 32'h0, PRDATA, rd;
	logic PREADY, PSLVERR, SEQ_BUSY, IRQ_ALLOW, FETCH_FAULT, DATA_IN_BANK, DATA_SFR_BAD;
	logic [3:0] SEQ_OP = 4'h0;
	logic [15:0] SEQ_ARG = 16'h0, DATA_ADDR = 16'h0, FETCH_ADDR, SP_VALUE, BANK_BASE, MEM_ADDR;
	logic ALU_WE = 1'b0, ALU_HALF = 1'b0, ALU_CARRY = 1'b0, DATA_WIDE = 1'b0;
	logic IRQ_PENDING = 1'b0, IRQ_LOW_PRIO = 1'b0, MEM_WE, MEM_RE, last_err;
	logic [7:0] ALU_RESULT = 8'h0, PSW_VALUE, MEM_WDATA, MEM_RDATA;
	logic [1:0] DATA_REGION;
	int n_fail = 0, compares = 0, cycles = 0;
	////////////////////////////////////////////////////////////
	cmm_ctrl #(.LEN_W(3)) cmm_ctrl_i (.SYS_CLK(SYS_CLK), .RST(RST), .PSEL(PSEL),
		.PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA),
		.PREADY(PREADY), .PSLVERR(PSLVERR), .SEQ_OP(SEQ_OP), .SEQ_ARG(SEQ_ARG),
		.SEQ_BUSY(SEQ_BUSY), .ALU_WE(ALU_WE), .ALU_RESULT(ALU_RESULT), .ALU_HALF(ALU_HALF),
		.ALU_CARRY(ALU_CARRY), .IRQ_PENDING(IRQ_PENDING), .IRQ_LOW_PRIO(IRQ_LOW_PRIO),
		.IRQ_ALLOW(IRQ_ALLOW), .FETCH_ADDR(FETCH_ADDR), .FETCH_FAULT(FETCH_FAULT),
		.PSW_VALUE(PSW_VALUE), .SP_VALUE(SP_VALUE), .BANK_BASE(BANK_BASE),
		.DATA_ADDR(DATA_ADDR), .DATA_WIDE(DATA_WIDE), .DATA_REGION(DATA_REGION),
		.DATA_IN_BANK(DATA_IN_BANK), .DATA_SFR_BAD(DATA_SFR_BAD), .MEM_ADDR(MEM_ADDR),
		.MEM_WDATA(MEM_WDATA), .MEM_WE(MEM_WE), .MEM_RE(MEM_RE), .MEM_RDATA(MEM_RDATA));
	cmm_mem_model cmm_mem_model_i (.clk(SYS_CLK), .addr(MEM_ADDR), .wdata(MEM_WDATA),
		.we(MEM_WE), .re(MEM_RE), .rdata(MEM_RDATA));
	////////////////////////////////////////////////////////////
	// clock and hang guard
	initial begin
		forever #20 SYS_CLK = ~SYS_CLK;
	end
	always @(posedge SYS_CLK) begin
		cycles++;
		if (cycles == 20000) begin
			n_fail++;
			wrap_up();
		end
	end
	////////////////////////////////////////////////////////////
	task automatic check(input logic [31:0] g, input logic [31:0] e);
		compares++;
		if (g !== e) begin
			n_fail++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge SYS_CLK);
	endtask
	task automatic wait_idle();
		int k;
		k = 0;
		do begin
			@(posedge SYS_CLK);
			k++;
		end while (SEQ_BUSY !== 1'b0 && k < 60);
	endtask
	// one apb transfer, held until pready is sampled high
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int k;
		@(posedge SYS_CLK);
		PSEL <= 1'b1;
		PWRITE <= w;
		PADDR <= a;
		PWDATA <= d;
		@(posedge SYS_CLK);
		PENABLE <= 1'b1;
		k = 0;
		do begin
			@(posedge SYS_CLK);
			k++;
		end while (PREADY !== 1'b1 && k < 20);
		rd = PRDATA;
		last_err = PSLVERR;
		PSEL <= 1'b0;
		PENABLE <= 1'b0;
	endtask
	// issue one sequencer op and let registered copies settle
	task automatic seq(input logic [3:0] op, input logic [15:0] arg);
		wait_idle();
		SEQ_OP <= op;
		SEQ_ARG <= arg;
		@(posedge SYS_CLK);
		SEQ_OP <= cmm_pkg::OP_NONE;
		tick(2);
		wait_idle();
		tick(3);
	endtask
	task automatic alu(input logic [7:0] r, input logic h, input logic c);
		ALU_RESULT <= r;
		ALU_HALF <= h;
		ALU_CARRY <= c;
		ALU_WE <= 1'b1;
		tick(1);
		ALU_WE <= 1'b0;
		tick(3);
	endtask
	////////////////////////////////////////////////////////////
	task automatic t_reset();
		wait_idle();
		tick(3);
		`CHK(FETCH_ADDR, 16'h1234);
		`CHK(PSW_VALUE, cmm_pkg::PSW_RST);
		`CHK(SEQ_BUSY, 1'b0);
		apb(1'b0, cmm_pkg::REG_PSW, 32'h0);
		`CHK(rd, 32'h02);
	endtask
	task automatic t_pc();
		seq(cmm_pkg::OP_ADVANCE, 16'h0003);
		`CHK(FETCH_ADDR, 16'h1237);
		seq(cmm_pkg::OP_ADVANCE, 16'h0004);
		`CHK(FETCH_ADDR, 16'h123b);
		seq(cmm_pkg::OP_BRANCH, 16'h7fff);
		`CHK(FETCH_FAULT, 1'b0);
		seq(cmm_pkg::OP_BRANCH, 16'h8000);
		`CHK(FETCH_FAULT, 1'b1);
		seq(cmm_pkg::OP_BRANCH, 16'hfb10);
		`CHK(FETCH_FAULT, 1'b1);
		seq(cmm_pkg::OP_BRANCH, 16'h0100);
		`CHK(FETCH_ADDR, 16'h0100);
	endtask
	task automatic t_ie();
		seq(cmm_pkg::OP_EI, 16'h0);
		`CHK(PSW_VALUE, 8'h82);
		IRQ_PENDING <= 1'b1;
		IRQ_LOW_PRIO <= 1'b1;
		tick(3);
		`CHK(IRQ_ALLOW, 1'b1);
		apb(1'b1, cmm_pkg::REG_PSW, 32'h80);
		tick(3);
		`CHK(IRQ_ALLOW, 1'b0);
		IRQ_LOW_PRIO <= 1'b0;
		tick(3);
		`CHK(IRQ_ALLOW, 1'b1);
		seq(cmm_pkg::OP_DI, 16'h0);
		`CHK(IRQ_ALLOW, 1'b0);
		`CHK(PSW_VALUE, 8'h00);
		IRQ_PENDING <= 1'b0;
	endtask
	task automatic t_alu();
		alu(8'h00, 1'b1, 1'b1);
		`CHK(PSW_VALUE, 8'h51);
		alu(8'h05, 1'b0, 1'b0);
		`CHK(PSW_VALUE, 8'h00);
	endtask
	task automatic t_bank();
		for (int b = 0; b < 4; b++) begin
			seq(cmm_pkg::OP_SEL_BANK, 16'(b));
			`CHK(PSW_VALUE, {2'h0, b[1], 1'h0, b[0], 3'h0});
			`CHK(BANK_BASE, 16'hfee0 + 16'(8 * b));
		end
		seq(cmm_pkg::OP_SEL_BANK, 16'h0);
	endtask
	task automatic t_irq();
		apb(1'b1, cmm_pkg::REG_SP, 32'hfee0);
		apb(1'b0, cmm_pkg::REG_SP, 32'h0);
		`CHK(rd, 32'hfee0);
		seq(cmm_pkg::OP_EI, 16'h0);
		seq(cmm_pkg::OP_IRQ_ACCEPT, 16'h0006);
		`CHK(cmm_mem_model_i.mem[16'hfedf], 8'h80);
		`CHK(cmm_mem_model_i.mem[16'hfede], 8'h01);
		`CHK(cmm_mem_model_i.mem[16'hfedd], 8'h00);
		`CHK(SP_VALUE, 16'hfedd);
		`CHK(FETCH_ADDR, 16'h0578);
		`CHK(PSW_VALUE, 8'h00);
		seq(cmm_pkg::OP_INT_RETURN, 16'h0);
		`CHK(FETCH_ADDR, 16'h0100);
		`CHK(PSW_VALUE, 8'h80);
		`CHK(SP_VALUE, 16'hfee0);
		apb(1'b0, cmm_pkg::REG_STAT, 32'h0);
		`CHK(rd[0], 1'b0);
		apb(1'b1, cmm_pkg::REG_SP, 32'h1000);
		seq(cmm_pkg::OP_PUSH_PSW, 16'h0);
		`CHK(cmm_mem_model_i.mem[16'h0fff], 8'h80);
		apb(1'b0, cmm_pkg::REG_STAT, 32'h0);
		`CHK(rd[0], 1'b1);
		apb(1'b1, cmm_pkg::REG_PSW, 32'h02);
		seq(cmm_pkg::OP_POP_PSW, 16'h0);
		`CHK(PSW_VALUE, 8'h80);
		`CHK(SP_VALUE, 16'h1000);
	endtask
	task automatic t_decode();
		logic [20:0] tb [9] = '{{16'h0000, 5'h00}, {16'h7fff, 5'h00}, {16'h8000, 5'h0c},
			{16'hfb00, 5'h04}, {16'hfedf, 5'h04}, {16'hfee0, 5'h06}, {16'hfeff, 5'h06},
			{16'hff00, 5'h18}, {16'hff01, 5'h19}};
		for (int i = 0; i < 9; i++) begin
			DATA_ADDR <= tb[i][20:5];
			DATA_WIDE <= tb[i][4];
			tick(3);
			`CHK({DATA_REGION, DATA_IN_BANK, DATA_SFR_BAD}, tb[i][3:0]);
		end
	endtask
	task automatic t_apb_err();
		apb(1'b0, 12'h010, 32'h0);
		`CHK(last_err, 1'b1);
		`CHK(rd, 32'h0);
		apb(1'b0, cmm_pkg::REG_PC, 32'h0);
		`CHK(rd, 32'h0100);
	endtask
	task automatic wrap_up();
		$display("compares=%0d n_fail=%0d", compares, n_fail);
		if (n_fail == 0 && compares > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask
	////////////////////////////////////////////////////////////
	// preload vectors, reset, run scenarios
	initial begin
		for (int i = 0; i < 65536; i++) begin
			cmm_mem_model_i.mem[i] = 8'h00;
		end
		cmm_mem_model_i.mem[0] = 8'h34;
		cmm_mem_model_i.mem[1] = 8'h12;
		cmm_mem_model_i.mem[6] = 8'h78;
		cmm_mem_model_i.mem[7] = 8'h05;
		tick(4);
		RST <= 1'b0;
		t_reset();
		t_pc();
		t_ie();
		t_alu();
		t_bank();
		t_irq();
		t_decode();
		t_apb_err();
		wrap_up();
	end
endmodule
`default_nettype wire
